// >>> rtl/sadc_ctrl.v
// state sequencer and pin handling of the converter
// Functional notes
// [RQ1] three states: reset, acquire, convert
// [RQ2] reset pin low for minimum width
// [RQ3] reset: config defaults, ready low, outputs hi-z
// [RQ4] host exits reset with trigger, clock quiet
// [RQ5] after exit delay enter acquire, ready high
// [RQ6] acquire/convert only while reset pin held high; code leaves them only after the pin is low for RST_LOW_CYC cycles
// [RQ7] trigger rise in acquire starts conversion
// [RQ8] internal oscillator times conversion within window
// [RQ9] forward reset, trigger; core returns status, result
// [RQ10] two's complement result with range saturation
// [RQ11] transfer clock: oscillator, serial clock, both
// [RQ12] ignore triggers until conversion ends
// [RQ13] status low converting, high when done
// [RQ14] ready follows status while select high
// [RQ15] reset exit delay at most 3 ms
// [RQ16] host waits for ready before new request
`timescale 1ns/100ps
`include "sadc_defines.vh"
module sadc_ctrl #(
  parameter RST_EXIT_CYC = `SADC_TDRST_CYC,
  parameter RST_LOW_CYC = `SADC_TWL_RST_CYC,
  parameter OSC_DIV = `SADC_OSC_DIV
) (
  input wire SYS_CLK_IN,
  input wire RSTN_IN,
  input wire RST_PIN_N_IN,
  input wire CONVERSION_TRIGGER_IN,
  input wire CS_N_IN,
  input wire SCLK_IN,
  input wire [1:0] XFER_CLK_SEL_IN,
  input wire signed [20:0] ANALOG_IN,
  output reg [1:0] STATE_OUT,
  output reg READY_STROBE_OUT,
  output reg SERIAL_DATA_OUTPUTS_OE_OUT,
  output reg CFG_DEFAULTS_OUT,
  output reg CORE_RESET_N_OUT,
  output reg CORE_TRIGGER_OUT,
  output reg CONVERSION_STATUS_INTERNAL_OUT,
  output reg [19:0] RESULT_OUT,
  output reg XFER_TICK_OUT
);
  reg rp_s1_r;
  reg rp_s2_r;
  reg trg_s1_r;
  reg trg_s2_r;
  reg trg_s3_r;
  reg cs_s1_r;
  reg cs_s2_r;
  reg sck_s1_r;
  reg sck_s2_r;
  reg sck_s3_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] low_cnt_r;
  reg [31:0] exit_cnt_r;
  reg start_r;
  wire trg_rise;
  wire sck_rise;
  wire low_done;
  wire exit_done;
  wire core_rstn;
  wire osc_tick;
  wire core_status;
  wire core_done;
  wire [19:0] core_result;
  reg ready_nxt;
  reg oe_nxt;
  reg status_nxt;
  reg tick_nxt;

  // state codes of the sequencer
  localparam [1:0] ST_RST = `SADC_ST_RST;
  localparam [1:0] ST_ACQ = `SADC_ST_ACQ;
  localparam [1:0] ST_CNV = `SADC_ST_CNV;

  assign trg_rise = trg_s2_r && !trg_s3_r;
  assign sck_rise = sck_s2_r && !sck_s3_r;
  // [RQ2] minimum low width
  assign low_done = (low_cnt_r >= RST_LOW_CYC - 1);
  // [RQ15] bounded exit delay
  assign exit_done = (exit_cnt_r >= RST_EXIT_CYC - 1);
  // [RQ9] reset forwarded to core
  assign core_rstn = RSTN_IN && CORE_RESET_N_OUT;

  // pins come from outside the clock domain
  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      rp_s1_r <= 1'b0;
      rp_s2_r <= 1'b0;
      trg_s1_r <= 1'b0;
      trg_s2_r <= 1'b0;
      trg_s3_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
    end else begin
      rp_s1_r <= RST_PIN_N_IN;
      rp_s2_r <= rp_s1_r;
      trg_s1_r <= CONVERSION_TRIGGER_IN;
      trg_s2_r <= trg_s1_r;
      trg_s3_r <= trg_s2_r;
      cs_s1_r <= CS_N_IN;
      cs_s2_r <= cs_s1_r;
      sck_s1_r <= SCLK_IN;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
    end
  end

  // [RQ1] state selection
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RST: begin
        // [RQ5] leave reset after delay
        if (rp_s2_r && exit_done)
          state_nxt = ST_ACQ;
      end
      ST_ACQ: begin
        // [RQ7] trigger starts conversion
        if (trg_rise)
          state_nxt = ST_CNV;
      end
      ST_CNV: begin
        // [RQ12] triggers ignored until done
        if (core_done)
          state_nxt = ST_ACQ;
      end
      default: state_nxt = ST_RST;
    endcase
    // [RQ6] reset pin must stay high
    if (!rp_s2_r && low_done)
      state_nxt = ST_RST;
  end

  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      state_r <= ST_RST;
      low_cnt_r <= 32'h00000000;
      exit_cnt_r <= 32'h00000000;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (rp_s2_r)
        low_cnt_r <= 32'h00000000;
      else if (!low_done)
        low_cnt_r <= low_cnt_r + 32'h00000001;
      if (state_r != ST_RST || !rp_s2_r)
        exit_cnt_r <= 32'h00000000;
      else if (!exit_done)
        exit_cnt_r <= exit_cnt_r + 32'h00000001;
      start_r <= (state_r == ST_ACQ) && trg_rise &&
                 !(!rp_s2_r && low_done);
    end
  end

  // [RQ14] ready mirrors status while deselected
  always @* begin
    status_nxt = core_status && !start_r;
    oe_nxt = (state_nxt != ST_RST) && !cs_s2_r;
    ready_nxt = (state_nxt != ST_RST) && cs_s2_r && status_nxt;
    // [RQ11] transfer clock source
    case (XFER_CLK_SEL_IN)
      `SADC_XCLK_OSC: tick_nxt = osc_tick;
      `SADC_XCLK_SCLK: tick_nxt = sck_rise;
      `SADC_XCLK_BOTH: tick_nxt = osc_tick || sck_rise;
      default: tick_nxt = osc_tick;
    endcase
  end

  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      STATE_OUT <= ST_RST;
      READY_STROBE_OUT <= 1'b0;
      SERIAL_DATA_OUTPUTS_OE_OUT <= 1'b0;
      CFG_DEFAULTS_OUT <= 1'b1;
      CORE_RESET_N_OUT <= 1'b0;
      CORE_TRIGGER_OUT <= 1'b0;
      CONVERSION_STATUS_INTERNAL_OUT <= 1'b1;
      RESULT_OUT <= `SADC_CODE_ZERO;
      XFER_TICK_OUT <= 1'b0;
    end else begin
      STATE_OUT <= state_nxt;
      // [RQ3] defaults held in reset
      CFG_DEFAULTS_OUT <= (state_nxt == ST_RST);
      SERIAL_DATA_OUTPUTS_OE_OUT <= oe_nxt;
      READY_STROBE_OUT <= ready_nxt;
      CORE_RESET_N_OUT <= (state_nxt != ST_RST);
      CORE_TRIGGER_OUT <= start_r;
      // [RQ13] status returned from core
      CONVERSION_STATUS_INTERNAL_OUT <= status_nxt;
      // [RQ10] coded result from core
      RESULT_OUT <= core_result;
      XFER_TICK_OUT <= tick_nxt;
    end
  end

  // [RQ8] oscillator-timed conversion
  sadc_core #(
    .OSC_DIV(OSC_DIV)
  ) u_core (
    .clk_in(SYS_CLK_IN),
    .rstn_in(core_rstn),
    .start_in(start_r),
    .analog_in(ANALOG_IN),
    .osc_tick_out(osc_tick),
    .status_out(core_status),
    .done_out(core_done),
    .result_out(core_result)
  );
endmodule // sadc_ctrl

// >>> rtl/sadc_defines.vh
// constants for the converter state control block
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// functional state encodings
`define SADC_ST_RST 2'h0
`define SADC_ST_ACQ 2'h1
`define SADC_ST_CNV 2'h2

// transfer clock source selections
`define SADC_XCLK_OSC 2'h0
`define SADC_XCLK_SCLK 2'h1
`define SADC_XCLK_BOTH 2'h2

// system clock rate
`define SADC_CLK_MHZ 100

// reset pin rising to ready rising, longest time
`define SADC_TDRST_MS 3
`define SADC_TDRST_CYC (`SADC_TDRST_MS * `SADC_CLK_MHZ * 1000)

// reset pin low width, least time
`define SADC_TWL_RST_NS 100
`define SADC_TWL_RST_CYC ((`SADC_TWL_RST_NS * `SADC_CLK_MHZ + 999) / 1000)

// conversion time window
`define SADC_TCONV_MIN_NS 400
`define SADC_TCONV_MAX_NS 500
`define SADC_TCONV_MIN_CYC ((`SADC_TCONV_MIN_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_TCONV_MAX_CYC ((`SADC_TCONV_MAX_NS * `SADC_CLK_MHZ) / 1000)

// internal oscillator divider and result width
`define SADC_OSC_DIV 2
`define SADC_RES_BITS 20

// result codes at the range limits and at zero
`define SADC_CODE_NEG_FS 20'h80000
`define SADC_CODE_ZERO 20'h00000
`define SADC_CODE_POS_FS 20'h7ffff

`endif

// >>> rtl/sadc_core.v
// successive-approximation converter core with its own oscillator
`timescale 1ns/100ps
`include "sadc_defines.vh"
module sadc_core #(
  parameter OSC_DIV = `SADC_OSC_DIV
) (
  input wire clk_in,
  input wire rstn_in,
  input wire start_in,
  input wire signed [20:0] analog_in,
  output reg osc_tick_out,
  output reg status_out,
  output reg done_out,
  output reg [19:0] result_out
);
  reg [7:0] div_r;
  reg busy_r;
  reg [4:0] bit_r;
  reg [19:0] samp_r;
  reg [19:0] trial_r;
  wire [19:0] cand;
  wire [19:0] clamped;
  wire [19:0] bit_mask;

  // saturate the sampled input to the 20-bit code range
  assign clamped = (analog_in < $signed(21'h180000)) ? `SADC_CODE_NEG_FS :
                   (analog_in > $signed(21'h07ffff)) ? `SADC_CODE_POS_FS :
                   analog_in[19:0];
  assign bit_mask = 20'h00001 << bit_r;
  assign cand = trial_r | bit_mask;

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      div_r <= 8'h00;
      osc_tick_out <= 1'b0;
    end else begin
      // free-running oscillator, cleared while the core is held in reset
      osc_tick_out <= (div_r == OSC_DIV[7:0] - 8'h01);
      if (div_r == OSC_DIV[7:0] - 8'h01)
        div_r <= 8'h00;
      else
        div_r <= div_r + 8'h01;
    end
  end

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      busy_r <= 1'b0;
      bit_r <= 5'h00;
      samp_r <= 20'h00000;
      trial_r <= 20'h00000;
      status_out <= 1'b1;
      done_out <= 1'b0;
      result_out <= `SADC_CODE_ZERO;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_r) begin
        // hold the sample in offset binary for the search
        samp_r <= clamped ^ `SADC_CODE_NEG_FS;
        trial_r <= 20'h00000;
        bit_r <= 5'h13;
        busy_r <= 1'b1;
        status_out <= 1'b0;
      end else if (busy_r && osc_tick_out) begin
        if (cand <= samp_r)
          trial_r <= cand;
        if (bit_r == 5'h00) begin
          busy_r <= 1'b0;
          status_out <= 1'b1;
          done_out <= 1'b1;
          // back to two's complement
          result_out <= ((cand <= samp_r) ? cand : trial_r) ^
                        `SADC_CODE_NEG_FS;
        end else begin
          bit_r <= bit_r - 5'h01;
        end
      end
    end
  end
endmodule // sadc_core

// >>> tb/sadc_host_model.sv
// host controller model driving the converter pins
`timescale 1ns/100ps
module sadc_host_model (
  input wire clk_in,
  output reg rst_n_out,
  output reg trig_out,
  output reg cs_n_out,
  output reg sclk_out
);
  initial begin
    rst_n_out = 1'b0;
    trig_out = 1'b0;
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
  end
  task rst_low(input integer n);
    begin
      rst_n_out = 1'b0;
      repeat (n) @(negedge clk_in);
      rst_n_out = 1'b1;
    end
  endtask
  task trig(input integer n);
    begin
      trig_out = 1'b1;
      repeat (n) @(negedge clk_in);
      trig_out = 1'b0;
    end
  endtask
  task sel(input v);
    cs_n_out = v;
  endtask
  // serial clock only inside a frame
  task clocks(input integer n);
    repeat (2 * n) begin
      @(negedge clk_in);
      sclk_out = ~sclk_out;
    end
  endtask
endmodule // sadc_host_model

// >>> tb/sadc_ctrl_monitor.sv
// assertion checker for the converter state control
`timescale 1ns/100ps
module sadc_ctrl_monitor (
  input wire SYS_CLK_IN,
  input wire RSTN_IN,
  input wire CS_N_IN,
  input wire [1:0] STATE_OUT,
  input wire READY_STROBE_OUT,
  input wire SERIAL_DATA_OUTPUTS_OE_OUT,
  input wire CFG_DEFAULTS_OUT,
  input wire CORE_RESET_N_OUT,
  input wire CORE_TRIGGER_OUT,
  input wire CONVERSION_STATUS_INTERNAL_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  reg [7:0] cnv_r;
  always @(posedge SYS_CLK_IN) begin
    cnv_r <= (STATE_OUT == 2'h2) ? cnv_r + 8'h01 : 8'h00;
  end
  property p_st; STATE_OUT != 2'h3; endproperty
  a_st: assert property (p_st) else $error("bad state");
  property p_rst; STATE_OUT == 2'h0 |-> !READY_STROBE_OUT &&
    !SERIAL_DATA_OUTPUTS_OE_OUT && CFG_DEFAULTS_OUT && !CORE_RESET_N_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_ex; $fell(STATE_OUT == 2'h0) |-> STATE_OUT == 2'h1 &&
    CORE_RESET_N_OUT && !CFG_DEFAULTS_OUT; endproperty
  a_ex: assert property (p_ex) else $error("reset exit");
  property p_go; STATE_OUT == 2'h1 ##1 STATE_OUT == 2'h2 |=>
    CORE_TRIGGER_OUT; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_len; $fell(STATE_OUT == 2'h2) && STATE_OUT == 2'h1 |->
    cnv_r >= 8'h28 && cnv_r <= 8'h32; endproperty
  a_len: assert property (p_len) else $error("conv time");
  property p_fw; CORE_TRIGGER_OUT |-> STATE_OUT == 2'h2 &&
    CORE_RESET_N_OUT; endproperty
  a_fw: assert property (p_fw) else $error("core start");
  property p_ign; CORE_TRIGGER_OUT |=> !CORE_TRIGGER_OUT [*8]; endproperty
  a_ign: assert property (p_ign) else $error("retrigger");
  property p_sta; CORE_TRIGGER_OUT |-> !CONVERSION_STATUS_INTERNAL_OUT;
  endproperty
  a_sta: assert property (p_sta) else $error("status");
  property p_rdy; CS_N_IN [*6] ##0 STATE_OUT != 2'h0 |->
    READY_STROBE_OUT == CONVERSION_STATUS_INTERNAL_OUT; endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
endmodule // sadc_ctrl_monitor
bind sadc_ctrl sadc_ctrl_monitor u_sadc_ctrl_monitor (.SYS_CLK_IN,
  .RSTN_IN, .CS_N_IN, .STATE_OUT, .READY_STROBE_OUT, .CFG_DEFAULTS_OUT,
  .SERIAL_DATA_OUTPUTS_OE_OUT, .CORE_RESET_N_OUT, .CORE_TRIGGER_OUT,
  .CONVERSION_STATUS_INTERNAL_OUT);

// >>> tb/testbench.sv
// self-checking bench for the converter state control
`timescale 1ns/100ps
module testbench;
  localparam EXIT = 20;
  localparam LOW = 3;
  reg clk, rstn;
  reg [1:0] xsel;
  reg signed [20:0] ain;
  reg [19:0] ticks;
  reg [19:0] t0;
  wire rst_n, trig, cs_n, sclk, rdy, oe, cfg, crst, ctrg, stat, tick;
  wire [1:0] st;
  wire [19:0] res;
  integer err_total, samples_checked, n;
  sadc_ctrl #(.RST_EXIT_CYC(EXIT), .RST_LOW_CYC(LOW), .OSC_DIV(2))
    u_sadc_ctrl (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .RST_PIN_N_IN(rst_n),
    .CONVERSION_TRIGGER_IN(trig), .CS_N_IN(cs_n), .SCLK_IN(sclk),
    .XFER_CLK_SEL_IN(xsel), .ANALOG_IN(ain), .STATE_OUT(st),
    .READY_STROBE_OUT(rdy), .SERIAL_DATA_OUTPUTS_OE_OUT(oe),
    .CFG_DEFAULTS_OUT(cfg), .CORE_RESET_N_OUT(crst),
    .CORE_TRIGGER_OUT(ctrg), .CONVERSION_STATUS_INTERNAL_OUT(stat),
    .RESULT_OUT(res), .XFER_TICK_OUT(tick));
  sadc_host_model u_sadc_host_model (.clk_in(clk), .rst_n_out(rst_n),
    .trig_out(trig), .cs_n_out(cs_n), .sclk_out(sclk));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // transfer tick counter, read as differences
  always @(posedge clk) begin
    if (!rstn)
      ticks <= 20'h00000;
    else if (tick === 1'b1)
      ticks <= ticks + 20'h00001;
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [19:0] got, input [19:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wait_st(input [1:0] s, input integer lim);
    begin
      n = 0;
      while (st !== s && n < lim) begin
        @(negedge clk);
        n = n + 1;
      end
      if (st !== s) begin
        err_total = err_total + 1;
        finish_test;
      end
    end
  endtask
  task t_exit;
    begin
      u_sadc_host_model.rst_low(LOW + 4);
      chk(st, 0);
      chk({oe, cfg, rdy}, 3'h2);
      wait_st(1, EXIT + 8);
      chk(n >= EXIT, 1);
      chk(rdy, 1);
    end
  endtask
  // system reset pulled in mid-run, then released again
  task t_sysrst;
    begin
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      chk(st, 0);
      chk({oe, cfg, rdy, stat}, 4'h5);
      chk(res, 20'h00000);
      rstn = 1'b1;
      wait_st(1, EXIT + 8);
      chk(rdy, 1);
    end
  endtask
  task t_conv(input signed [20:0] a, input [19:0] exp);
    begin
      ain = a;
      u_sadc_host_model.trig(2);
      wait_st(2, 6);
      u_sadc_host_model.trig(2);
      wait_st(1, 60);
      chk(stat, 1);
      chk(res, exp);
      repeat (6) @(negedge clk);
      chk(st, 1);
    end
  endtask
  task t_cs;
    begin
      xsel = 2'h1;
      u_sadc_host_model.sel(1'b0);
      repeat (6) @(negedge clk);
      chk({rdy, oe}, 2'h1);
      t0 = ticks;
      u_sadc_host_model.clocks(5);
      repeat (4) @(negedge clk);
      chk(ticks - t0, 5);
      u_sadc_host_model.sel(1'b1);
      xsel = 2'h0;
      t0 = ticks;
      // first window also counts the idle tick of the serial mode
      repeat (41) @(negedge clk);
      chk(ticks - t0, 20);
      xsel = 2'h2;
      t0 = ticks;
      repeat (40) @(negedge clk);
      chk(ticks - t0, 20);
      xsel = 2'h3;
      t0 = ticks;
      repeat (40) @(negedge clk);
      chk(ticks - t0, 20);
      xsel = 2'h0;
    end
  endtask
  initial begin
    rstn = 1'b0;
    xsel = 2'h0;
    ain = 21'h000000;
    err_total = 0;
    samples_checked = 0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_exit;
    t_conv(21'h17ffff, 20'h80000);
    t_conv(21'h180000, 20'h80000);
    t_conv(21'h1fffff, 20'hfffff);
    t_conv(21'h000000, 20'h00000);
    t_conv(21'h07ffff, 20'h7ffff);
    t_conv(21'h080000, 20'h7ffff);
    t_cs;
    t_sysrst;
    u_sadc_host_model.rst_low(LOW - 2);
    repeat (6) @(negedge clk);
    chk(st, 1);
    t_exit;
    finish_test;
  end
endmodule // testbench
